// *** rtl/pms_defs.svh ***
// Constants for the power mode selector.
`ifndef PMS_DEFS_SVH
`define PMS_DEFS_SVH

`define PMS_ADDR_W          4
`define PMS_ADDR_SPK        4'h6
`define PMS_SPK_W           5
`define PMS_SPK_RST         5'h1F
`define PMS_BIT_RECV        0
`define PMS_BIT_TONE        1
`define PMS_BIT_EAR         2
`define PMS_BIT_ACC         3
`define PMS_BIT_RSVD        4
`define PMS_ADDR_STAT       4'h8
`define PMS_ACT_TIMEOUT_NS  250000

`endif

// *** rtl/pms_pkg.sv ***
// Types shared by the power mode selector.
package pms_pkg;
	// Gray ordered along the recommended power-up path.
	typedef enum logic [1:0] {
		PMS_OFF  = 2'b00,
		PMS_VREF = 2'b01,
		PMS_TONE = 2'b11,
		PMS_NORM = 2'b10
	} pms_mode_t;
endpackage

// *** rtl/pms_power_mode_selector.sv ***
// Power mode selector: pin mode decode, speaker amp switches, codec idle detect.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "pms_defs.svh"

module pms_power_mode_selector #(
	parameter int CLK_MHZ        = 100,
	parameter int ACT_TIMEOUT_NS = `PMS_ACT_TIMEOUT_NS
) (
	// Clock and reset.
	input  wire logic                    clk_i,
	input  wire logic                    rst_b_i,
	// Mode select pins.
	input  wire logic                    mode_select_lo_i,
	input  wire logic                    mode_select_mid_i,
	input  wire logic                    mode_select_hi_i,
	// Codec timing inputs and serial data from the codec core.
	input  wire logic                    frame_sync_i,
	input  wire logic                    bit_clk_i,
	input  wire logic                    codec_data_i,
	// Register port.
	input  wire logic [`PMS_ADDR_W-1:0]  addr_i,
	input  wire logic [7:0]              wdata_i,
	input  wire logic                    wr_i,
	input  wire logic                    rd_i,
	output logic      [7:0]              rdata_o,
	// Power and output controls.
	output pms_pkg::pms_mode_t           mode_o,
	output logic                         ref_en_o,
	output logic                         tone_gen_en_o,
	output logic                         codec_en_o,
	output logic                         codec_partial_pd_o,
	output logic                         receiver_amp_en_o,
	output logic                         earphone_amp_en_o,
	output logic                         tone_amp_en_o,
	output logic                         accessory_output_en_o,
	output logic                         pcm_dout_o
);
	import pms_pkg::*;

	localparam int ACT_CYC_RAW = (ACT_TIMEOUT_NS * CLK_MHZ) / 1000;
	localparam int ACT_CYC     = (ACT_CYC_RAW < 1) ? 1 : ACT_CYC_RAW;
	localparam int CNT_W       = $clog2(ACT_CYC + 1);

	// Refuse a clock rate or timeout that is not positive.
	if (CLK_MHZ < 1 || ACT_TIMEOUT_NS < 1) begin : g_bad_cfg
		$error("pms: clock rate and timeout must be positive");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode decode.

	// Lowest pin dominates, so a mid-change of the upper pins never drops normal mode.
	function automatic pms_mode_t decode_mode(input logic lo, input logic mid,
		input logic hi);
		if (lo)
			decode_mode = PMS_NORM;
		else if (mid)
			decode_mode = PMS_TONE;
		else if (hi)
			decode_mode = PMS_VREF;
		else
			decode_mode = PMS_OFF;
	endfunction

	pms_mode_t mode_d;
	assign mode_d = decode_mode(mode_select_lo_i, mode_select_mid_i, mode_select_hi_i);

	// The mode is registered so every output leaves a flip-flop.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode_o        <= PMS_OFF;
			ref_en_o      <= 1'b0;
			tone_gen_en_o <= 1'b0;
			codec_en_o    <= 1'b0;
		end else begin
			mode_o        <= mode_d;
			ref_en_o      <= (mode_d != PMS_OFF);
			tone_gen_en_o <= (mode_d == PMS_TONE) || (mode_d == PMS_NORM);
			codec_en_o    <= (mode_d == PMS_NORM);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Speaker switch register.

	logic [`PMS_SPK_W-1:0] spk_sw_q;

	// Reset leaves all amps off so power-up makes no noise.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			spk_sw_q <= `PMS_SPK_RST;
		else if (wr_i && addr_i == `PMS_ADDR_SPK)
			spk_sw_q <= wdata_i[`PMS_SPK_W-1:0];
	end

	// Amps need the reference and at least tone mode; a one bit floats the amp.
	logic amp_mode;
	assign amp_mode = (mode_d == PMS_TONE) || (mode_d == PMS_NORM);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			receiver_amp_en_o     <= 1'b0;
			earphone_amp_en_o     <= 1'b0;
			tone_amp_en_o         <= 1'b0;
			accessory_output_en_o <= 1'b0;
		end else begin
			receiver_amp_en_o     <= amp_mode && !spk_sw_q[`PMS_BIT_RECV];
			earphone_amp_en_o     <= amp_mode && !spk_sw_q[`PMS_BIT_EAR];
			tone_amp_en_o         <= amp_mode && !spk_sw_q[`PMS_BIT_TONE];
			accessory_output_en_o <= amp_mode && !spk_sw_q[`PMS_BIT_ACC];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Codec activity detect.

	logic             fs_q;
	logic             bc_q;
	logic [CNT_W-1:0] idle_cnt_q;
	logic             edge_ok_q;

	// Any edge on either timing input restarts the idle count.
	// The first sample after reset has no history, so it is not taken as an edge;
	// otherwise an idle-high sync pin would fake a wake-up right after reset.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fs_q       <= 1'b0;
			bc_q       <= 1'b0;
			edge_ok_q  <= 1'b0;
			idle_cnt_q <= CNT_W'(ACT_CYC);
		end else begin
			fs_q      <= frame_sync_i;
			bc_q      <= bit_clk_i;
			edge_ok_q <= 1'b1;
			if (edge_ok_q && ((fs_q != frame_sync_i) || (bc_q != bit_clk_i)))
				idle_cnt_q <= '0;
			else if (idle_cnt_q != CNT_W'(ACT_CYC))
				idle_cnt_q <= idle_cnt_q + 1'b1;
		end
	end

	// Both inputs static past the timeout counts as stopped, at either level.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			codec_partial_pd_o <= 1'b1;
		else
			codec_partial_pd_o <= (idle_cnt_q == CNT_W'(ACT_CYC));
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial data output.

	// Held high outside normal mode and while the codec is partly down.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			pcm_dout_o <= 1'b1;
		else if (mode_d == PMS_NORM && !codec_partial_pd_o)
			pcm_dout_o <= codec_data_i;
		else
			pcm_dout_o <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register read.

	// The switch register is write-only; a status word reports mode and idle state.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			rdata_o <= 8'h00;
		else if (rd_i && addr_i == `PMS_ADDR_STAT)
			rdata_o <= {5'h00, codec_partial_pd_o, mode_o};
		else
			rdata_o <= 8'h00;
	end
endmodule

// *** verification/pms_chk_sva.sv ***
// Port checker for the power mode selector.
`timescale 1ns/1ps
`include "pms_defs.svh"
module pms_chk import pms_pkg::*; (
	input wire logic clk_i, rst_b_i, wr_i, rd_i, bit_clk_i,
	input wire logic mode_select_lo_i, mode_select_mid_i, mode_select_hi_i,
	input wire logic [`PMS_ADDR_W-1:0] addr_i,
	input wire logic [7:0] wdata_i, rdata_o,
	input wire pms_pkg::pms_mode_t mode_o,
	input wire logic ref_en_o, codec_en_o, codec_partial_pd_o, pcm_dout_o,
	input wire logic receiver_amp_en_o, earphone_amp_en_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	norm_mode_a: assert property (mode_select_lo_i |=> mode_o == PMS_NORM)
		else $error("normal mode missed");
	tone_mode_a: assert property (!mode_select_lo_i && mode_select_mid_i |=>
		mode_o == PMS_TONE) else $error("tone mode missed");
	ref_mode_a: assert property (!mode_select_lo_i && !mode_select_mid_i &&
		mode_select_hi_i |=> mode_o == PMS_VREF) else $error("reference mode missed");
	full_off_a: assert property ({mode_select_lo_i, mode_select_mid_i,
		mode_select_hi_i} == 3'h0 |=> mode_o == PMS_OFF && !ref_en_o) else $error("not off");
	codec_gate_a: assert property (codec_en_o == (mode_o == PMS_NORM))
		else $error("codec enable wrong");
	pcm_idle_a: assert property (mode_o != PMS_NORM |-> pcm_dout_o)
		else $error("serial out not high");
	amp_off_a: assert property (wr_i && addr_i == 4'h6 && wdata_i[0] |=>
		##1 !receiver_amp_en_o) else $error("receiver amp still on");
	amp_on_a: assert property (wr_i && addr_i == 4'h6 && !wdata_i[2] && mode_select_lo_i
		##1 mode_select_lo_i && !wr_i |=> earphone_amp_en_o) else $error("earphone amp off");
	wake_codec_a: assert property ($changed(bit_clk_i) |-> ##2 !codec_partial_pd_o)
		else $error("codec still idle");
	wo_read_a: assert property (rd_i && addr_i != 4'h8 |=> rdata_o == 8'h00)
		else $error("read data not zero");
endmodule
bind pms_power_mode_selector pms_chk u_chk (.*);

// *** verification/pms_host_clk.sv ***
// Host timing source: bit clock and frame sync, still while not running.
`timescale 1ns/1ps
module pms_host_clk (
	input  wire logic clk_i,
	input  wire logic run_i,
	output logic      bit_clk_o,
	output logic      frame_sync_o
);
	logic [9:0] cnt_q = 10'h000;
	// One frame is 256 bit clocks, each four system clocks long; scaled for speed.
	always_ff @(posedge clk_i) if (run_i) cnt_q <= cnt_q + 10'h001;
	assign bit_clk_o    = cnt_q[1];
	assign frame_sync_o = cnt_q[9:2] == 8'h00;
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the power mode selector.
`timescale 1ns/1ps
module tb_top;
	import pms_pkg::*;
	logic clk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, codec_data_i = 1'b0, run = 1'b0;
	logic mode_select_lo_i = 1'b0, mode_select_mid_i = 1'b0, mode_select_hi_i = 1'b0;
	logic frame_sync_i, bit_clk_i, ref_en_o, tone_gen_en_o, codec_en_o, codec_partial_pd_o;
	logic receiver_amp_en_o, earphone_amp_en_o, tone_amp_en_o, accessory_output_en_o, pcm_dout_o;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00, rdata_o;
	pms_mode_t mode_o;
	int errors = 0, cmp_count = 0;
	pms_power_mode_selector #(.ACT_TIMEOUT_NS(200)) u_dut (.*);
	pms_host_clk u_host (.clk_i(clk_i), .run_i(run), .bit_clk_o(bit_clk_i), .frame_sync_o(frame_sync_i));
	// Free-running 100 MHz clock.
	initial forever #5 clk_i = ~clk_i;
	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i) {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
		@(posedge clk_i) wr_i <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_i) {addr_i, rd_i} <= {a, 1'b1};
		@(posedge clk_i) rd_i <= 1'b0;
		#1 chk(rdata_o, e);
	endtask
	task pins(input logic [2:0] p);
		@(posedge clk_i) {mode_select_hi_i, mode_select_mid_i, mode_select_lo_i} <= p;
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	////////////////////////////////////////////////////////////////
	// Every pin pattern, decoded lowest pin first.
	task t_modes;
		for (int i = 0; i < 8; i++) begin
			pins(3'(i));
			chk(mode_o, i[0] ? PMS_NORM : i[1] ? PMS_TONE : i[2] ? PMS_VREF : PMS_OFF);
			chk({ref_en_o, tone_gen_en_o, codec_en_o}, {i != 0, i[1] | i[0], i[0]});
			chk(pcm_dout_o, 1'b1);
		end
	endtask
	// One amp on at a time, then the off mode overrides the switches.
	task t_amps;
		pins(3'h1);
		for (int b = 0; b < 4; b++) begin
			wr(4'h6, 8'h1F & ~(8'h01 << b));
			pins(3'h1);
			chk({accessory_output_en_o, earphone_amp_en_o, tone_amp_en_o, receiver_amp_en_o}, 8'h01 << b);
		end
		wr(4'h6, 8'h00);
		pins(3'h0);
		chk(receiver_amp_en_o | earphone_amp_en_o | tone_amp_en_o | accessory_output_en_o, 1'b0);
		rd(4'h6, 8'h00);
		rd(4'hF, 8'h00);
	endtask
	// Codec wakes on a running bit clock and idles again when it stops.
	task t_codec;
		int n;
		pins(3'h4);
		pins(3'h2);
		wr(4'h7, 8'h00);
		pins(3'h1);
		@(posedge clk_i) run <= 1'b1;
		for (n = 0; n < 60 && codec_partial_pd_o !== 1'b0; n++) begin
			@(posedge clk_i);
			#1;
		end
		if (n == 60) begin errors++; test_done(); end
		rd(4'h8, {6'h00, PMS_NORM});
		for (int v = 0; v < 2; v++) begin
			@(posedge clk_i) codec_data_i <= v[0];
			repeat (2) @(posedge clk_i);
			#1 chk(pcm_dout_o, v[0]);
		end
		@(posedge clk_i) {run, codec_data_i} <= 2'b00;
		repeat (40) @(posedge clk_i);
		#1 chk({codec_partial_pd_o, pcm_dout_o}, 2'b11);
	endtask
	task test_done;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Reset for 20 cycles, then the scenarios.
	initial begin
		repeat (20) @(posedge clk_i);
		rst_b_i <= 1'b1;
		t_modes();
		t_amps();
		t_codec();
		test_done();
	end
endmodule
